// file: design/deep_sleep_wake_sequencer.sv
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

module deep_sleep_wake_sequencer #(
   parameter int RTC_DIV = wake_seq_pkg::RTC_DIV,
   parameter int SHORT_SLEEP_CYC = wake_seq_pkg::SHORT_SLEEP_CYC,
   parameter int RESTORE_CYC = wake_seq_pkg::RESTORE_CYC
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rd_data_o,
   // wake pins and power condition
   input wire logic ring_indicate_pin_n_i,
   input wire logic external_wake_pin_n_i,
   input wire logic ext_reset_pin_n_i,
   input wire logic rtc_event_i,
   input wire logic rtc_clk_i,
   input wire logic adapter_power_ok_i,
   input wire logic battery_power_ok_i,
   // on-chip sources
   input wire logic general_port_b_irq10_i,
   input wire logic bus_idle_i,
   input wire logic bus_access_i,
   // sequencer outputs
   output logic slow_mode_o,
   output logic bus_hold_o,
   output logic short_sleep_o,
   output logic deep_sleep_o,
   output logic cpu_clk_stop_o,
   output logic irq_o
);

   // ==========================================================
   // parameter checks
   if (RTC_DIV < 2 || RTC_DIV > 255) begin : g_div_chk
      $error("RTC_DIV out of range");
   end
   if (SHORT_SLEEP_CYC < 1 || SHORT_SLEEP_CYC > 255) begin : g_ss_chk
      $error("SHORT_SLEEP_CYC out of range");
   end
   if (RESTORE_CYC < 1 || RESTORE_CYC > 255) begin : g_rs_chk
      $error("RESTORE_CYC out of range");
   end

   localparam logic [7:0] DIV_LAST = 8'(RTC_DIV - 1);
   localparam logic [7:0] SS_LAST = 8'(SHORT_SLEEP_CYC - 1);
   localparam logic [7:0] RS_LAST = 8'(RESTORE_CYC - 1);

   // ==========================================================
   // state
   typedef struct packed {
      logic [wake_seq_pkg::PIN_W-1:0] pin_s1;
      logic [wake_seq_pkg::PIN_W-1:0] pin_s2;
      logic rtc_clk_prev;
      logic rtc_evt_prev;
      logic [7:0] div_cnt;
      logic [wake_seq_pkg::DEB_W-1:0] hist0;
      logic [wake_seq_pkg::DEB_W-1:0] hist1;
      logic [wake_seq_pkg::DEB_W-1:0] deb_prev;
      logic [3:0] mode;
      logic [wake_seq_pkg::EVT_W-1:0] status;
      logic [wake_seq_pkg::EVT_W-1:0] mask;
      wake_seq_pkg::seq_state_t state;
      logic [7:0] wait_cnt;
      logic [31:0] rd_data;
      logic bus_hold;
      logic short_sleep;
      logic deep_sleep;
      logic cpu_clk_stop;
      logic irq;
   } seq_regs_t;

   seq_regs_t cur;
   seq_regs_t next_cur;

   // ==========================================================
   // next state
   always_comb begin
      logic [wake_seq_pkg::DEB_W-1:0] act;
      logic [wake_seq_pkg::DEB_W-1:0] deb;
      logic [wake_seq_pkg::EVT_W-1:0] evt;
      logic [wake_seq_pkg::EVT_W-1:0] clr;
      logic tick;
      logic rtc_evt;
      logic wake_any;
      logic power_ok;
      logic wake_q;
      act = '0;
      deb = '0;
      evt = '0;
      clr = '0;
      tick = 1'b0;
      rtc_evt = 1'b0;
      wake_any = 1'b0;
      power_ok = 1'b0;
      wake_q = 1'b0;
      next_cur = cur;

      // two-flop synchronisers on every pin
      next_cur.pin_s1 = {battery_power_ok_i, adapter_power_ok_i, rtc_clk_i, rtc_event_i,
         ext_reset_pin_n_i, external_wake_pin_n_i, ring_indicate_pin_n_i};
      next_cur.pin_s2 = cur.pin_s1;
      next_cur.rtc_clk_prev = cur.pin_s2[wake_seq_pkg::PIN_RTC_CLK];
      next_cur.rtc_evt_prev = cur.pin_s2[wake_seq_pkg::PIN_RTC_EVENT];

      // debounce tick from the rtc clock; stops when that clock stops
      if (cur.pin_s2[wake_seq_pkg::PIN_RTC_CLK] && !cur.rtc_clk_prev) begin
         if (cur.div_cnt == DIV_LAST) begin
            next_cur.div_cnt = 8'h00;
            tick = 1'b1;
         end else begin
            next_cur.div_cnt = cur.div_cnt + 8'h01;
         end
      end

      // active levels of debounced sources
      act[wake_seq_pkg::SRC_RING] = !cur.pin_s2[wake_seq_pkg::PIN_RING_N];
      act[wake_seq_pkg::SRC_EXT_WAKE] =
         !cur.pin_s2[wake_seq_pkg::PIN_EXT_WAKE_N];
      act[wake_seq_pkg::SRC_SYNC_REQ] = general_port_b_irq10_i;
      act[wake_seq_pkg::SRC_EXT_RESET] =
         !cur.pin_s2[wake_seq_pkg::PIN_EXT_RESET_N];
      if (tick) begin
         next_cur.hist0 = act;
         next_cur.hist1 = cur.hist0;
      end
      deb = cur.hist0 & cur.hist1;
      next_cur.deb_prev = deb;
      rtc_evt = cur.pin_s2[wake_seq_pkg::PIN_RTC_EVENT];

      // wake qualification, unmaskable
      wake_any = (|deb) || rtc_evt;
      power_ok = cur.pin_s2[wake_seq_pkg::PIN_ADAPTER_OK]
         || cur.pin_s2[wake_seq_pkg::PIN_BATTERY_OK];
      wake_q = wake_any
         && (power_ok || cur.mode[wake_seq_pkg::MODE_IGNORE_POWER_BIT]);

      // interrupt events
      for (int i = 0; i < 3; i++) begin
         evt[i] = deb[i] && !cur.deb_prev[i];
      end
      evt[wake_seq_pkg::EVT_RTC] = rtc_evt && !cur.rtc_evt_prev;

      // register writes
      if (wr_i) begin
         if (addr_i == wake_seq_pkg::MODE_ADDR) begin
            next_cur.mode = wr_data_i[3:0];
            // sleep request only taken in slow mode
            next_cur.mode[wake_seq_pkg::MODE_SLEEP_REQ_BIT] =
               wr_data_i[wake_seq_pkg::MODE_SLEEP_REQ_BIT]
               && wr_data_i[wake_seq_pkg::MODE_SLOW_BIT];
         end else if (addr_i == wake_seq_pkg::STATUS_ADDR) begin
            clr = wr_data_i[wake_seq_pkg::EVT_W-1:0];
         end else if (addr_i == wake_seq_pkg::MASK_ADDR) begin
            next_cur.mask = wr_data_i[wake_seq_pkg::EVT_W-1:0];
         end
      end

      // sequencer
      case (cur.state)
         wake_seq_pkg::ST_RUN: begin
            if (cur.mode[wake_seq_pkg::MODE_SLEEP_REQ_BIT]) begin
               if (wake_any) begin
                  next_cur.mode[wake_seq_pkg::MODE_SLEEP_REQ_BIT] = 1'b0;
                  evt[wake_seq_pkg::EVT_REFUSED] = 1'b1;
               end else begin
                  next_cur.state = wake_seq_pkg::ST_WAIT_IDLE;
               end
            end
         end
         wake_seq_pkg::ST_WAIT_IDLE: begin
            if (wake_any) begin
               next_cur.mode[wake_seq_pkg::MODE_SLEEP_REQ_BIT] = 1'b0;
               evt[wake_seq_pkg::EVT_REFUSED] = 1'b1;
               next_cur.state = wake_seq_pkg::ST_RUN;
            end else if (bus_idle_i) begin
               next_cur.state = wake_seq_pkg::ST_WAIT_ACCESS;
            end
         end
         wake_seq_pkg::ST_WAIT_ACCESS: begin
            if (wake_any) begin
               next_cur.mode[wake_seq_pkg::MODE_SLEEP_REQ_BIT] = 1'b0;
               evt[wake_seq_pkg::EVT_REFUSED] = 1'b1;
               next_cur.state = wake_seq_pkg::ST_RUN;
            end else if (bus_access_i) begin
               next_cur.bus_hold = 1'b1;
               next_cur.short_sleep = 1'b1;
               next_cur.wait_cnt = 8'h00;
               next_cur.state = wake_seq_pkg::ST_SHORT_SLEEP;
            end
         end
         wake_seq_pkg::ST_SHORT_SLEEP: begin
            if (cur.wait_cnt == SS_LAST) begin
               next_cur.short_sleep = 1'b0;
               next_cur.deep_sleep = 1'b1;
               next_cur.cpu_clk_stop = 1'b1;
               next_cur.state = wake_seq_pkg::ST_DEEP_SLEEP;
            end else begin
               next_cur.wait_cnt = cur.wait_cnt + 8'h01;
            end
         end
         wake_seq_pkg::ST_DEEP_SLEEP: begin
            if (wake_q) begin
               next_cur.cpu_clk_stop = 1'b0;
               next_cur.wait_cnt = 8'h00;
               next_cur.state = wake_seq_pkg::ST_RESTORE;
            end
         end
         wake_seq_pkg::ST_RESTORE: begin
            if (cur.wait_cnt == RS_LAST) begin
               next_cur.bus_hold = 1'b0;
               next_cur.state = wake_seq_pkg::ST_RELEASE;
            end else begin
               next_cur.wait_cnt = cur.wait_cnt + 8'h01;
            end
         end
         wake_seq_pkg::ST_RELEASE: begin
            next_cur.deep_sleep = 1'b0;
            next_cur.mode[wake_seq_pkg::MODE_SLEEP_REQ_BIT] = 1'b0;
            evt[wake_seq_pkg::EVT_WOKE] = 1'b1;
            next_cur.state = wake_seq_pkg::ST_RUN;
         end
         default: begin
            next_cur.state = wake_seq_pkg::ST_RUN;
         end
      endcase

      // sticky status, set wins over clear; mask only gates the irq
      next_cur.status = (cur.status & ~clr) | evt;
      next_cur.irq = |(next_cur.status & next_cur.mask);

      // register reads
      next_cur.rd_data = 32'h0000_0000;
      if (rd_i) begin
         if (addr_i == wake_seq_pkg::MODE_ADDR) begin
            next_cur.rd_data[3:0] = cur.mode;
         end else if (addr_i == wake_seq_pkg::STATUS_ADDR) begin
            next_cur.rd_data[wake_seq_pkg::EVT_W-1:0] = cur.status;
         end else if (addr_i == wake_seq_pkg::MASK_ADDR) begin
            next_cur.rd_data[wake_seq_pkg::EVT_W-1:0] = cur.mask;
         end else if (addr_i == wake_seq_pkg::STATE_ADDR) begin
            next_cur.rd_data[2:0] = cur.state;
            next_cur.rd_data[7:4] = deb;
            next_cur.rd_data[8] = rtc_evt;
            next_cur.rd_data[9] = power_ok;
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         cur.pin_s1 <= wake_seq_pkg::PIN_RESET;
         cur.pin_s2 <= wake_seq_pkg::PIN_RESET;
         cur.rtc_clk_prev <= 1'b0;
         cur.rtc_evt_prev <= 1'b0;
         cur.div_cnt <= 8'h00;
         cur.hist0 <= '0;
         cur.hist1 <= '0;
         cur.deb_prev <= '0;
         cur.mode <= wake_seq_pkg::MODE_RESET;
         cur.status <= wake_seq_pkg::STATUS_RESET;
         cur.mask <= wake_seq_pkg::MASK_RESET;
         cur.state <= wake_seq_pkg::ST_RUN;
         cur.wait_cnt <= 8'h00;
         cur.rd_data <= 32'h0000_0000;
         cur.bus_hold <= 1'b0;
         cur.short_sleep <= 1'b0;
         cur.deep_sleep <= 1'b0;
         cur.cpu_clk_stop <= 1'b0;
         cur.irq <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   // ==========================================================
   // outputs
   assign rd_data_o = cur.rd_data;
   assign slow_mode_o = cur.mode[wake_seq_pkg::MODE_SLOW_BIT];
   assign bus_hold_o = cur.bus_hold;
   assign short_sleep_o = cur.short_sleep;
   assign deep_sleep_o = cur.deep_sleep;
   assign cpu_clk_stop_o = cur.cpu_clk_stop;
   assign irq_o = cur.irq;

endmodule // deep_sleep_wake_sequencer

// file: include/wake_seq_pkg.sv
package wake_seq_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] MODE_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] MASK_ADDR = 8'h08;
   localparam logic [7:0] STATE_ADDR = 8'h0c;

   // ==========================================================
   // mode register fields
   localparam int MODE_SLOW_BIT = 0;
   localparam int MODE_SLEEP_REQ_BIT = 1;
   localparam int MODE_IGNORE_POWER_BIT = 3;
   localparam logic [3:0] MODE_RESET = 4'h0;

   // ==========================================================
   // status and mask fields
   localparam int EVT_W = 6;
   localparam int EVT_RING = 0;
   localparam int EVT_EXT_WAKE = 1;
   localparam int EVT_SYNC_REQ = 2;
   localparam int EVT_RTC = 3;
   localparam int EVT_WOKE = 4;
   localparam int EVT_REFUSED = 5;
   localparam logic [5:0] STATUS_RESET = 6'h00;
   localparam logic [5:0] MASK_RESET = 6'h00;

   // ==========================================================
   // debounced sources
   localparam int DEB_W = 4;
   localparam int SRC_RING = 0;
   localparam int SRC_EXT_WAKE = 1;
   localparam int SRC_SYNC_REQ = 2;
   localparam int SRC_EXT_RESET = 3;

   // ==========================================================
   // synchronised pins
   localparam int PIN_W = 7;
   localparam int PIN_RING_N = 0;
   localparam int PIN_EXT_WAKE_N = 1;
   localparam int PIN_EXT_RESET_N = 2;
   localparam int PIN_RTC_EVENT = 3;
   localparam int PIN_RTC_CLK = 4;
   localparam int PIN_ADAPTER_OK = 5;
   localparam int PIN_BATTERY_OK = 6;
   localparam logic [6:0] PIN_RESET = 7'h67;

   // ==========================================================
   // timing
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int RTC_CLK_HZ = 32_768;
   localparam int TICK_HZ = 250;
   localparam int RTC_DIV = RTC_CLK_HZ / TICK_HZ;
   localparam int SHORT_SLEEP_NS = 200;
   localparam int SHORT_SLEEP_CYC =
      (SHORT_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESTORE_NS = 500;
   localparam int RESTORE_CYC = (RESTORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_RUN,
      ST_WAIT_IDLE,
      ST_WAIT_ACCESS,
      ST_SHORT_SLEEP,
      ST_DEEP_SLEEP,
      ST_RESTORE,
      ST_RELEASE
   } seq_state_t;

endpackage

// file: sim/deep_sleep_wake_sequencer_sva.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module deep_sleep_wake_sequencer_sva #(
   parameter int SHORT_SLEEP_CYC = 8,
   parameter int RESTORE_CYC = 20
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // watched ports
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rd_data_o,
   input wire logic bus_access_i,
   input wire logic slow_mode_o,
   input wire logic bus_hold_o,
   input wire logic short_sleep_o,
   input wire logic deep_sleep_o,
   input wire logic cpu_clk_stop_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);
   slow_write_a: assert property (
      wr_i && addr_i == wake_seq_pkg::MODE_ADDR |=> slow_mode_o == $past(wr_data_i[0]))
      else $error("slow mode bit not loaded");
   bus_take_a: assert property (
      $rose(bus_hold_o) |-> $past(bus_access_i) && slow_mode_o)
      else $error("bus taken without access");
   short_start_a: assert property (
      $rose(bus_hold_o) |-> $rose(short_sleep_o))
      else $error("short sleep not entered with bus");
   short_len_a: assert property (
      $rose(short_sleep_o) |-> ##SHORT_SLEEP_CYC (deep_sleep_o && cpu_clk_stop_o && !short_sleep_o))
      else $error("short sleep length wrong");
   deep_entry_a: assert property (
      $rose(deep_sleep_o) |-> $past(short_sleep_o) && bus_hold_o)
      else $error("deep sleep without short sleep");
   stop_in_deep_a: assert property (
      cpu_clk_stop_o |-> deep_sleep_o && bus_hold_o)
      else $error("clock stopped outside deep sleep");
   restore_seq_a: assert property (
      $fell(cpu_clk_stop_o) |-> deep_sleep_o ##RESTORE_CYC (!bus_hold_o && deep_sleep_o)
      ##1 !deep_sleep_o)
      else $error("restore order wrong");
   rd_idle_a: assert property (
      !$past(rd_i) |-> rd_data_o == 32'h0)
      else $error("read data outside read slot");
endmodule // deep_sleep_wake_sequencer_sva

bind deep_sleep_wake_sequencer deep_sleep_wake_sequencer_sva #(
   .SHORT_SLEEP_CYC(SHORT_SLEEP_CYC),
   .RESTORE_CYC(RESTORE_CYC)
) sva_chk (
   .mclk_i, .rst_b_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .bus_access_i,
   .slow_mode_o, .bus_hold_o, .short_sleep_o, .deep_sleep_o, .cpu_clk_stop_o
);

// file: sim/wake_far_side.sv
`timescale 1ns/1ps
// ==========================================================
// wake pins, power monitors and processor bus
module wake_far_side (
   // clock and controls
   input wire logic mclk_i,
   input wire logic [4:0] wake_i,
   input wire logic [1:0] pwr_i,
   input wire logic rtc_run_i,
   input wire logic busy_i,
   // pins toward the block
   output logic ring_n_o,
   output logic ext_wake_n_o,
   output logic ext_reset_n_o,
   output logic rtc_event_o,
   output logic rtc_clk_o,
   output logic adapter_power_ok_o,
   output logic battery_power_ok_o,
   output logic port_b_irq10_o,
   output logic bus_idle_o,
   output logic bus_access_o
);
   logic [1:0] cnt = 2'h0;
   initial rtc_clk_o = 1'b0;
   initial bus_access_o = 1'b0;
   always @(posedge mclk_i) begin
      cnt <= cnt + 2'h1;
      if (rtc_run_i) rtc_clk_o <= cnt[1];
      bus_access_o <= !busy_i && cnt == 2'h3;
   end
   assign ring_n_o = !wake_i[0];
   assign ext_wake_n_o = !wake_i[1];
   assign port_b_irq10_o = wake_i[2];
   assign ext_reset_n_o = !wake_i[3];
   assign rtc_event_o = wake_i[4];
   assign adapter_power_ok_o = pwr_i[0];
   assign battery_power_ok_o = pwr_i[1];
   assign bus_idle_o = !busy_i;
endmodule // wake_far_side

// file: sim/deep_sleep_wake_sequencer_test.sv
`timescale 1ns/1ps
// ==========================================================
// bench top
module deep_sleep_wake_sequencer_test;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wr_data_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [4:0] wake = 5'h00;
   logic [1:0] pwr = 2'h3;
   logic rtc_run = 1'b1;
   logic busy = 1'b0;
   logic [31:0] rd_data_o;
   logic ring_n, ext_n, rst_n, rtc_ev, rtc_clk, adp, bat, irq10, idle, acc;
   logic slow_mode_o, bus_hold_o, short_sleep_o, deep_sleep_o, cpu_clk_stop_o, irq_o;
   int n_mismatch = 0;
   int cmp_count = 0;
   localparam logic [5:0] EXP [5] = '{6'h11, 6'h12, 6'h14, 6'h10, 6'h18};
   always #12.5 mclk_i = !mclk_i;
   deep_sleep_wake_sequencer #(.RTC_DIV(2)) DUT (
      .mclk_i, .rst_b_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
      .ring_indicate_pin_n_i(ring_n), .external_wake_pin_n_i(ext_n),
      .ext_reset_pin_n_i(rst_n), .rtc_event_i(rtc_ev), .rtc_clk_i(rtc_clk),
      .adapter_power_ok_i(adp), .battery_power_ok_i(bat), .general_port_b_irq10_i(irq10),
      .bus_idle_i(idle), .bus_access_i(acc), .slow_mode_o, .bus_hold_o, .short_sleep_o,
      .deep_sleep_o, .cpu_clk_stop_o, .irq_o);
   wake_far_side far (
      .mclk_i, .wake_i(wake), .pwr_i(pwr), .rtc_run_i(rtc_run), .busy_i(busy),
      .ring_n_o(ring_n), .ext_wake_n_o(ext_n), .ext_reset_n_o(rst_n), .rtc_event_o(rtc_ev),
      .rtc_clk_o(rtc_clk), .adapter_power_ok_o(adp), .battery_power_ok_o(bat),
      .port_b_irq10_o(irq10), .bus_idle_o(idle), .bus_access_o(acc));
   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic wait_deep(input logic v);
      #1;
      repeat (300) begin
         if (deep_sleep_o !== v) begin
            @(posedge mclk_i);
            #1;
         end
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      check(rd_data_o, exp);
   endtask
   task automatic settle();
      wake <= 5'h00;
      cyc(40);
      wr(wake_seq_pkg::STATUS_ADDR, 32'h3f);
   endtask
   task automatic go_sleep(input logic [3:0] m);
      busy <= 1'b1;
      wr(wake_seq_pkg::MODE_ADDR, {28'h0, m});
      cyc(20);
      check(bus_hold_o, 32'h0);
      busy <= 1'b0;
      wait_deep(1'b1);
      check(cpu_clk_stop_o, 32'h1);
   endtask
   // ==========================================================
   // scenarios
   task automatic refuse();
      wake[0] <= 1'b1;
      cyc(40);
      wr(wake_seq_pkg::MODE_ADDR, 32'h3);
      cyc(20);
      check(bus_hold_o, 32'h0);
      rd(wake_seq_pkg::STATUS_ADDR, 32'h21);
      rd(wake_seq_pkg::MODE_ADDR, 32'h1);
      settle();
   endtask
   task automatic sleep_wake(input int s, input logic [3:0] m, input logic [1:0] p,
      input logic [5:0] exp);
      logic [5:0] msk;
      msk = (s % 2) ? 6'h10 : 6'h00;
      pwr <= p;
      wr(wake_seq_pkg::MASK_ADDR, {26'h0, msk});
      go_sleep(m);
      wake[s] <= 1'b1;
      wait_deep(1'b0);
      check(bus_hold_o, 32'h0);
      wake[s] <= 1'b0;
      cyc(40);
      rd(wake_seq_pkg::STATUS_ADDR, {26'h0, exp});
      check(irq_o, {31'h0, |(exp & msk)});
      rd(wake_seq_pkg::MODE_ADDR, {28'h0, m & 4'hd});
      wr(wake_seq_pkg::STATUS_ADDR, 32'h3f);
      rd(wake_seq_pkg::STATUS_ADDR, 32'h0);
      check(irq_o, 32'h0);
   endtask
   task automatic pwr_gate();
      pwr <= 2'b00;
      go_sleep(4'h3);
      wake[1] <= 1'b1;
      cyc(150);
      check(deep_sleep_o, 32'h1);
      pwr <= 2'b01;
      wait_deep(1'b0);
      check(deep_sleep_o, 32'h0);
      settle();
   endtask
   task automatic no_wake();
      go_sleep(4'h3);
      wake[1] <= 1'b1;
      cyc(3);
      wake[1] <= 1'b0;
      cyc(60);
      check(deep_sleep_o, 32'h1);
      rtc_run <= 1'b0;
      wake[1] <= 1'b1;
      cyc(150);
      check(deep_sleep_o, 32'h1);
      rtc_run <= 1'b1;
      wait_deep(1'b0);
      check(deep_sleep_o, 32'h0);
      settle();
   endtask
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rd(wake_seq_pkg::MODE_ADDR, 32'h0);
      rd(wake_seq_pkg::STATUS_ADDR, 32'h0);
      rd(wake_seq_pkg::MASK_ADDR, 32'h0);
      rd(wake_seq_pkg::STATE_ADDR, 32'h200);
      rd(8'h10, 32'h0);
      refuse();
      for (int s = 0; s < 5; s++) begin
         sleep_wake(s, 4'h3, (s % 2) ? 2'b01 : 2'b10, EXP[s]);
      end
      sleep_wake(1, 4'hb, 2'b00, 6'h12);
      pwr_gate();
      no_wake();
      print_verdict();
   end
   initial begin
      #1000000;
      n_mismatch++;
      print_verdict();
   end
endmodule // deep_sleep_wake_sequencer_test
